// >>> rtl/flash_vcr_map.svh
// Purpose: Offsets, reset values, opcodes and frame counts of the volatile configuration bank
// Assumes: Only the low address byte selects a location
// Notes:   Definitions only
`ifndef FLASH_VCR_MAP_SVH
`define FLASH_VCR_MAP_SVH

// ----------------------------------------
// Register locations
// ----------------------------------------
`define VCR_TRAIN_PATTERN 8'h0A
`define VCR_INTEGRITY_CTRL 8'h0B
`define VCR_INTEGRITY_STAT 8'h0C
`define VCR_FIRST_ADDR_LOW 8'h0D
`define VCR_FIRST_ADDR_MID 8'h0E
`define VCR_FIRST_ADDR_HIGH 8'h0F
`define VCR_FIRST_ADDR_TOP 8'h10
`define VCR_BANK_ACTIVITY 8'h11

// ----------------------------------------
// Reset values and read fillers
// ----------------------------------------
`define VCR_ERASED_BYTE 8'hFF
`define VCR_TRAIN_RESET 8'h55
`define VCR_CTRL_RESET 8'hFF
`define VCR_STAT_RESET 8'h00
`define VCR_FIRST_ADDR_RESET 28'hFFF_FFFF
`define VCR_LOW_NIBBLE_FILL 4'h0
`define VCR_TALLY_MAX 4'hF
`define VCR_BANK_IDLE 3'b000
`define VCR_LANE3_MASK 8'h08

// ----------------------------------------
// Link commands and frame bit counts
// ----------------------------------------
`define VCR_OP_WRITE_ENABLE 8'h06
`define VCR_OP_WRITE_VCR 8'h81
`define VCR_OP_READ_VCR 8'h85
`define VCR_LAST_OPCODE_BIT 6'd7
`define VCR_LAST_ADDR_BIT 6'd39
`define VCR_LAST_DATA_BIT 6'd47

`endif

// >>> rtl/flash_vcr_pkg.sv
// Purpose: Types shared by the volatile configuration bank
// Assumes: Field order follows the bit order of each location
// Notes:   Constants live in flash_vcr_map.svh
package flash_vcr_pkg;

  // ----------------------------------------
  // Location 0Bh, bit 7 down to bit 0
  // ----------------------------------------
  typedef struct packed {
    logic readParityDisable;
    logic line3InvertDisable;
    logic [1:0] programCheckChunkSize;
    logic programParityDisable;
    logic errorEventSelect;
    logic errorPinDisable;
    logic correctionDisable;
  } integrity_ctrl_t;

  // ----------------------------------------
  // Location 0Ch, bit 7 down to bit 0
  // ----------------------------------------
  typedef struct packed {
    logic illegalReprogramFlag;
    logic [3:0] correctionEventTally;
    logic doubleBitErrorFlag;
    logic addrParityErrorFlag;
    logic dataCheckErrorFlag;
  } integrity_stat_t;

  // ----------------------------------------
  // Event strobes from the array engine
  // ----------------------------------------
  typedef struct packed {
    logic corrEvent;
    logic doubleEvent;
    logic reprogramAttempt;
    logic addrParityError;
    logic dataCrcError;
    logic boundaryViolation;
    logic [27:0] chunkAddr;
  } array_events_t;

  // Phase of a link frame
  typedef enum logic [3:0] {
    PH_OPCODE = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_IGNORE = 4'b1000
  } frame_phase_t;

endpackage : flash_vcr_pkg

// >>> rtl/flash_volatile_config_regs.sv
// Purpose: Volatile configuration locations 08h..FFh reached over a serial link
// Assumes: Link pins are asynchronous, sampled twice; events come from sys_clk logic
// Notes:   Single-line SPI framing, mode 0, read and write one byte per frame
//
// Operation
// R1: Reset loads erased ones unless field differs
// R2: Only the low address byte selects
// R3: Reserved locations read back all ones
// R4: Reserved write ignored, flag set, latch cleared
// R5: Bank field shows busy bank or 000
// R6: Record chunk address of first event
// R7: Flag incremental programming while ECC on
// R8: Event tally counts, saturates at fifteen
// R9: Flag any two-bit error
// R10: Flag address parity errors
// R11: Flag data check or boundary errors
// R12: Read parity enabled when bit low
// R13: Training line 3 inverted when bit low
// R14: Chunk size select, default sixteen bytes
// R15: Program parity enabled when bit low
// R16: Event select for pin and address
// R17: Error pin enabled when bit low
// R18: ECC on when bit low
// R19: Training pattern byte, default 55h
// R20: Host sets write enable before writing
`timescale 1ns/1ps
`include "flash_vcr_map.svh"

module flash_volatile_config_regs (
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic linkClk, // Serial clock from host
  input wire logic linkSelN, // Chip select, active low
  input wire logic linkDataIn, // Serial data into the device
  output logic linkDataOut, // Serial data to host
  output logic linkDataOe, // Drive enable of linkDataOut
  input wire flash_vcr_pkg::array_events_t arrayEvents, // Array event strobes
  input wire logic progEraseActive, // Program or erase running
  input wire logic [1:0] progEraseBank, // Bank under program or erase
  input wire logic flagStatusClear, // Clears the reserved write flag
  output flash_vcr_pkg::integrity_ctrl_t integrityCtrl, // Control byte 0Bh
  output logic [7:0] trainingPatternValue, // Training pattern 0Ah
  output logic [7:0] laneInvertMask, // Lanes inverted in training
  output logic errorPinN, // Error indication, active low
  output logic writeEnableLatch, // Write enable latch state
  output logic flagStatusWriteError // Flag status bit 1
);

  // ----------------------------------------
  // Link synchronisers
  // ----------------------------------------
  logic [1:0] clkSync; // Two-stage clock sampler
  logic [1:0] selSync; // Two-stage select sampler
  logic [1:0] dinSync; // Two-stage data sampler
  logic clkLast; // Previous synced clock

  // Edge detection reads only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clkSync <= 2'b00;
      selSync <= 2'b11;
      dinSync <= 2'b00;
      clkLast <= 1'b0;
    end else begin
      clkSync <= {clkSync[0], linkClk};
      selSync <= {selSync[0], linkSelN};
      dinSync <= {dinSync[0], linkDataIn};
      clkLast <= clkSync[1];
    end
  end

  logic clkRise; // Rising link edge seen
  logic clkFall; // Falling link edge seen
  logic selIdle; // Frame not active
  logic dataBit; // Synced data bit
  assign clkRise = clkSync[1] & ~clkLast;
  assign clkFall = ~clkSync[1] & clkLast;
  assign selIdle = selSync[1];
  assign dataBit = dinSync[1];

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  flash_vcr_pkg::frame_phase_t phase; // Frame phase
  flash_vcr_pkg::frame_phase_t next_phase;
  logic [5:0] bitCnt; // Bits received this frame
  logic [5:0] next_bitCnt;
  logic [6:0] shiftIn; // Partial received byte
  logic [6:0] next_shiftIn;
  logic [7:0] opcode; // Current command
  logic [7:0] next_opcode;
  logic [7:0] regAddr; // Selected location
  logic [7:0] next_regAddr;
  logic [7:0] readByte; // Byte being returned
  logic [7:0] next_readByte;
  logic next_linkDataOut;
  logic next_linkDataOe;
  logic [7:0] next_trainingPatternValue;
  flash_vcr_pkg::integrity_ctrl_t next_integrityCtrl;
  logic next_writeEnableLatch;
  logic next_flagStatusWriteError;
  flash_vcr_pkg::integrity_stat_t integrityStat; // Status byte 0Ch
  flash_vcr_pkg::integrity_stat_t next_integrityStat;
  logic [27:0] firstEventChunkAddr; // Chunk address of first event
  logic [27:0] next_firstEventChunkAddr;
  logic firstCaptured; // First event already held
  logic next_firstCaptured;
  logic [2:0] busyBankCode; // Location 11h field
  logic [2:0] next_busyBankCode;
  logic next_errorPinN;
  logic [7:0] next_laneInvertMask;

  // ----------------------------------------
  // Read decode
  // ----------------------------------------
  // Value presented for a location
  function automatic logic [7:0] readMux(input logic [7:0] addr);
    logic [7:0] val;
    val = `VCR_ERASED_BYTE;
    case (addr)
      `VCR_TRAIN_PATTERN: val = trainingPatternValue;
      `VCR_INTEGRITY_CTRL: val = integrityCtrl;
      `VCR_INTEGRITY_STAT: val = integrityStat;
      // R6: low nibble zero
      `VCR_FIRST_ADDR_LOW: val = {firstEventChunkAddr[3:0], `VCR_LOW_NIBBLE_FILL};
      `VCR_FIRST_ADDR_MID: val = firstEventChunkAddr[11:4];
      `VCR_FIRST_ADDR_HIGH: val = firstEventChunkAddr[19:12];
      `VCR_FIRST_ADDR_TOP: val = firstEventChunkAddr[27:20];
      `VCR_BANK_ACTIVITY: val = {5'b0_0000, busyBankCode};
      // R3: reserved reads ones
      default: val = `VCR_ERASED_BYTE;
    endcase
    return val;
  endfunction : readMux

  // ----------------------------------------
  // Frame decoder and register writes
  // ----------------------------------------
  // Command, address and data phases of one frame
  always_comb begin
    next_phase = phase;
    next_bitCnt = bitCnt;
    next_shiftIn = shiftIn;
    next_opcode = opcode;
    next_regAddr = regAddr;
    next_readByte = readByte;
    next_linkDataOut = linkDataOut;
    next_linkDataOe = linkDataOe;
    next_trainingPatternValue = trainingPatternValue;
    next_integrityCtrl = integrityCtrl;
    next_writeEnableLatch = writeEnableLatch;
    next_flagStatusWriteError = flagStatusWriteError;
    if (flagStatusClear) begin
      next_flagStatusWriteError = 1'b0;
    end
    if (selIdle) begin
      // Deselect aborts any frame and releases the line
      next_phase = flash_vcr_pkg::PH_OPCODE;
      next_bitCnt = 6'd0;
      next_linkDataOe = 1'b0;
    end else if (clkRise) begin
      next_shiftIn = {shiftIn[5:0], dataBit};
      next_bitCnt = bitCnt + 6'd1;
      case (phase)
        flash_vcr_pkg::PH_OPCODE: begin
          if (bitCnt == `VCR_LAST_OPCODE_BIT) begin
            next_opcode = {shiftIn, dataBit};
            if ({shiftIn, dataBit} == `VCR_OP_WRITE_ENABLE) begin
              // R20: latch armed by host
              next_writeEnableLatch = 1'b1;
              next_phase = flash_vcr_pkg::PH_IGNORE;
            end else if ({shiftIn, dataBit} == `VCR_OP_WRITE_VCR ||
                         {shiftIn, dataBit} == `VCR_OP_READ_VCR) begin
              next_phase = flash_vcr_pkg::PH_ADDR;
            end else begin
              next_phase = flash_vcr_pkg::PH_IGNORE;
            end
          end
        end
        flash_vcr_pkg::PH_ADDR: begin
          if (bitCnt == `VCR_LAST_ADDR_BIT) begin
            // R2: keep only final byte
            next_regAddr = {shiftIn, dataBit};
            next_readByte = readMux({shiftIn, dataBit});
            next_phase = flash_vcr_pkg::PH_DATA;
          end
        end
        flash_vcr_pkg::PH_DATA: begin
          if (bitCnt == `VCR_LAST_DATA_BIT) begin
            next_phase = flash_vcr_pkg::PH_IGNORE;
            // Without the latch a write is silently dropped
            if (opcode == `VCR_OP_WRITE_VCR && writeEnableLatch) begin
              next_writeEnableLatch = 1'b0;
              case (regAddr)
                // R19: pattern byte write
                `VCR_TRAIN_PATTERN: next_trainingPatternValue = {shiftIn, dataBit};
                // R12: control byte write
                `VCR_INTEGRITY_CTRL: next_integrityCtrl = {shiftIn, dataBit};
                default: begin
                  // R4: reserved write refused
                  next_flagStatusWriteError = 1'b1;
                end
              endcase
            end
          end
        end
        default: begin
          next_bitCnt = bitCnt;
        end
      endcase
    end else if (clkFall) begin
      // Read data leaves on falling edges, MSB first
      if (phase == flash_vcr_pkg::PH_DATA && opcode == `VCR_OP_READ_VCR) begin
        next_linkDataOut = readByte[3'd7 - bitCnt[2:0]];
        next_linkDataOe = 1'b1;
      end else begin
        next_linkDataOe = 1'b0;
      end
    end
  end

  // R1: erased defaults at reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= flash_vcr_pkg::PH_OPCODE;
      bitCnt <= 6'd0;
      shiftIn <= 7'h00;
      opcode <= 8'h00;
      regAddr <= 8'h00;
      readByte <= `VCR_ERASED_BYTE;
      linkDataOut <= 1'b0;
      linkDataOe <= 1'b0;
      trainingPatternValue <= `VCR_TRAIN_RESET;
      integrityCtrl <= `VCR_CTRL_RESET;
      writeEnableLatch <= 1'b0;
      flagStatusWriteError <= 1'b0;
    end else begin
      phase <= next_phase;
      bitCnt <= next_bitCnt;
      shiftIn <= next_shiftIn;
      opcode <= next_opcode;
      regAddr <= next_regAddr;
      readByte <= next_readByte;
      linkDataOut <= next_linkDataOut;
      linkDataOe <= next_linkDataOe;
      trainingPatternValue <= next_trainingPatternValue;
      integrityCtrl <= next_integrityCtrl;
      writeEnableLatch <= next_writeEnableLatch;
      flagStatusWriteError <= next_flagStatusWriteError;
    end
  end

  // ----------------------------------------
  // Integrity status and first event
  // ----------------------------------------
  logic eccOn; // ECC enabled
  logic qualifyingEvent; // Event type chosen for address capture
  // R18: ECC on when low
  assign eccOn = ~integrityCtrl.correctionDisable;
  // R16: select event type
  assign qualifyingEvent = integrityCtrl.errorEventSelect ? arrayEvents.doubleEvent
                                                          : arrayEvents.corrEvent;

  // Sticky flags; nothing clears them short of reset
  always_comb begin
    next_integrityStat = integrityStat;
    next_firstEventChunkAddr = firstEventChunkAddr;
    next_firstCaptured = firstCaptured;
    // R7: incremental program attempt
    if (eccOn && arrayEvents.reprogramAttempt) begin
      next_integrityStat.illegalReprogramFlag = 1'b1;
    end
    // R8: saturating event tally
    if (eccOn && (arrayEvents.corrEvent || arrayEvents.doubleEvent) &&
        integrityStat.correctionEventTally != `VCR_TALLY_MAX) begin
      next_integrityStat.correctionEventTally = integrityStat.correctionEventTally + 4'd1;
    end
    // R9: two-bit detection
    if (arrayEvents.doubleEvent) begin
      next_integrityStat.doubleBitErrorFlag = 1'b1;
    end
    // R10: address parity error
    if (arrayEvents.addrParityError) begin
      next_integrityStat.addrParityErrorFlag = 1'b1;
    end
    // R11: CRC or boundary error
    if (arrayEvents.dataCrcError || arrayEvents.boundaryViolation) begin
      next_integrityStat.dataCheckErrorFlag = 1'b1;
    end
    // R6: capture first chunk only
    if (eccOn && qualifyingEvent && !firstCaptured) begin
      next_firstEventChunkAddr = arrayEvents.chunkAddr;
      next_firstCaptured = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      integrityStat <= `VCR_STAT_RESET;
      firstEventChunkAddr <= `VCR_FIRST_ADDR_RESET;
      firstCaptured <= 1'b0;
    end else begin
      integrityStat <= next_integrityStat;
      firstEventChunkAddr <= next_firstEventChunkAddr;
      firstCaptured <= next_firstCaptured;
    end
  end

  // ----------------------------------------
  // Bank activity, error pin, training lanes
  // ----------------------------------------
  // Derived outputs, registered so the pins never glitch
  always_comb begin
    // R5: busy bank code
    next_busyBankCode = progEraseActive ? {1'b1, progEraseBank} : `VCR_BANK_IDLE;
    // R17: pin enabled when low
    next_errorPinN = ~(~integrityCtrl.errorPinDisable && eccOn &&
                       (integrityCtrl.errorEventSelect ? integrityStat.doubleBitErrorFlag
                                                       : integrityStat.correctionEventTally != 4'h0));
    // R13: invert line 3
    next_laneInvertMask = integrityCtrl.line3InvertDisable ? 8'h00 : `VCR_LANE3_MASK;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busyBankCode <= `VCR_BANK_IDLE;
      errorPinN <= 1'b1;
      laneInvertMask <= 8'h00;
    end else begin
      busyBankCode <= next_busyBankCode;
      errorPinN <= next_errorPinN;
      laneInvertMask <= next_laneInvertMask;
    end
  end

  // Chunk size and program parity only leave on integrityCtrl;
  // the array and link datapaths outside this bank act on them,
  // so no local logic depends on those fields
  // R14: chunk size on integrityCtrl
  // R15: program parity on integrityCtrl

endmodule : flash_volatile_config_regs

// >>> testbench/vcr_checker_monitor.sv
// Purpose: Port checks for the volatile configuration bank
// Assumes: One sys_clk domain, rst synchronous
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps

module vcr_checker (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Reset
  input wire logic linkClk, // Link clock
  input wire logic linkSelN, // Select
  input wire logic linkDataIn, // Data in
  input wire logic linkDataOut, // Data out
  input wire logic linkDataOe, // Out enable
  input wire flash_vcr_pkg::array_events_t arrayEvents, // Events
  input wire logic progEraseActive, // Busy
  input wire logic [1:0] progEraseBank, // Busy bank
  input wire logic flagStatusClear, // Flag clear
  input wire flash_vcr_pkg::integrity_ctrl_t integrityCtrl, // 0Bh
  input wire logic [7:0] trainingPatternValue, // 0Ah
  input wire logic [7:0] laneInvertMask, // Mask
  input wire logic errorPinN, // Error pin
  input wire logic writeEnableLatch, // Latch
  input wire logic flagStatusWriteError // Flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_mask_follows: assert property ($stable(integrityCtrl) |->
    laneInvertMask == (integrityCtrl.line3InvertDisable ? 8'h00 : 8'h08)) else $error("lane mask wrong");
  // Pin stays high while off or ECC off
  a_pin_off: assert property ($past(integrityCtrl[1] | integrityCtrl[0]) &&
    (integrityCtrl[1] | integrityCtrl[0]) |-> errorPinN) else $error("error pin low while off");
  a_pin_double: assert property (integrityCtrl[2:0] == 3'b100 && arrayEvents.doubleEvent
    |-> ##[1:3] !errorPinN) else $error("no pin on double error");
  a_pin_tally: assert property (integrityCtrl[2:0] == 3'b000 && arrayEvents.corrEvent
    |-> ##[1:3] !errorPinN) else $error("no pin on correction");
  // Flags are sticky, so the pin holds
  a_pin_sticky: assert property (!errorPinN && $stable(integrityCtrl) |=> !errorPinN)
    else $error("error pin released");
  a_flag_latch: assert property ($rose(flagStatusWriteError) |-> !writeEnableLatch)
    else $error("latch kept on refused write");
  a_write_frame: assert property ($changed(integrityCtrl) || $changed(trainingPatternValue)
    |-> !$past(linkSelN)) else $error("register moved outside frame");
  a_write_clear: assert property ($changed(integrityCtrl) || $changed(trainingPatternValue)
    |-> ##[0:1] !writeEnableLatch) else $error("latch kept after write");
  a_oe_idle: assert property (linkSelN [*5] |-> !linkDataOe)
    else $error("drive while deselected");
  a_latch_frame: assert property ($rose(writeEnableLatch) |-> !$past(linkSelN))
    else $error("latch set outside frame");
endmodule : vcr_checker

bind flash_volatile_config_regs vcr_checker vcr_chk_u (.sys_clk, .rst, .linkClk, .linkSelN,
  .linkDataIn, .linkDataOut, .linkDataOe, .arrayEvents, .progEraseActive, .progEraseBank,
  .flagStatusClear, .integrityCtrl, .trainingPatternValue, .laneInvertMask, .errorPinN,
  .writeEnableLatch, .flagStatusWriteError);

// >>> testbench/host_link_model.sv
// Purpose: Host side of the serial link, mode 0, MSB first
// Assumes: 160 ns link period, eight sys_clk
// Notes:   Link clock idles low between frames
`timescale 1ns/1ps
`include "flash_vcr_map.svh"

module host_link_model (
  input wire logic sys_clk, // System clock
  output logic linkClk, // Serial clock
  output logic linkSelN, // Select, low
  output logic linkDataIn, // Data to device
  input wire logic linkDataOut, // Data from device
  input wire logic linkDataOe // Device drive
);
  int oeMiss; // Data bits whose drive state does not match the opcode

  initial begin
    linkClk = 1'b0;
    linkSelN = 1'b1;
    linkDataIn = 1'b0;
    oeMiss = 0;
  end

  // Send n bits; last byte read back
  // address carries four bytes
  task automatic frame(input logic [47:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge sys_clk);
    linkSelN = 1'b0;
    for (int i = 0; i < n; i++) begin
      linkDataIn = bits[47 - i];
      repeat (4) @(negedge sys_clk);
      linkClk = 1'b1;
      repeat (4) @(negedge sys_clk);
      if (i >= 40) begin
        // Undriven line reads as the inverse, never the stale bit
        rd[47 - i] = linkDataOe ? linkDataOut : ~linkDataOut;
        // Only a read frame may drive the line
        if (linkDataOe !== (bits[47:40] == `VCR_OP_READ_VCR)) oeMiss++;
      end
      linkClk = 1'b0;
    end
    // Hold select so the commit lands inside
    repeat (8) @(negedge sys_clk);
    linkSelN = 1'b1;
    // Released line shows no stale bit
    linkDataIn = ~linkDataIn;
    repeat (4) @(negedge sys_clk);
  endtask : frame
endmodule : host_link_model

// >>> testbench/tb_flash_volatile_config_regs.sv
// Purpose: Self-checking bench of the volatile configuration bank
// Assumes: Host model drives the link
// Notes:   Inputs change at falling sys_clk
`timescale 1ns/1ps
`include "flash_vcr_map.svh"

module tb_flash_volatile_config_regs;
  logic sys_clk = 1'b0; // Only the clock process toggles it
  logic rst, linkClk, linkSelN, linkDataIn, linkDataOut, linkDataOe;
  logic progEraseActive, flagStatusClear, errorPinN, writeEnableLatch, flagStatusWriteError;
  logic [1:0] progEraseBank;
  logic [7:0] trainingPatternValue, laneInvertMask;
  flash_vcr_pkg::array_events_t arrayEvents;
  flash_vcr_pkg::integrity_ctrl_t integrityCtrl;
  int fail_count, n_tests;

  always #10 sys_clk = ~sys_clk;

  host_link_model host_u (.sys_clk(sys_clk), .linkClk(linkClk), .linkSelN(linkSelN),
    .linkDataIn(linkDataIn), .linkDataOut(linkDataOut), .linkDataOe(linkDataOe));
  flash_volatile_config_regs dut_u (.sys_clk(sys_clk), .rst(rst), .linkClk(linkClk),
    .linkSelN(linkSelN), .linkDataIn(linkDataIn), .linkDataOut(linkDataOut),
    .linkDataOe(linkDataOe), .arrayEvents(arrayEvents), .progEraseActive(progEraseActive),
    .progEraseBank(progEraseBank), .flagStatusClear(flagStatusClear),
    .integrityCtrl(integrityCtrl), .trainingPatternValue(trainingPatternValue),
    .laneInvertMask(laneInvertMask), .errorPinN(errorPinN),
    .writeEnableLatch(writeEnableLatch), .flagStatusWriteError(flagStatusWriteError));

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Upper address bytes are junk on purpose
  task automatic rd(input logic [7:0] loc, output logic [7:0] v);
    host_u.frame({`VCR_OP_READ_VCR, 24'hC3_5A96, loc, 8'h00}, 48, v);
  endtask : rd

  task automatic wr(input logic [7:0] loc, input logic [7:0] d, input bit en);
    logic [7:0] junk;
    if (en) host_u.frame({`VCR_OP_WRITE_ENABLE, 40'h00_0000_0000}, 8, junk);
    host_u.frame({`VCR_OP_WRITE_VCR, 24'h7E_813C, loc, d}, 48, junk);
  endtask : wr

  // One-cycle event; k picks the strobe
  task automatic pulse(input int k, input logic [27:0] a);
    @(negedge sys_clk);
    arrayEvents = {6'(1 << k), a};
    @(negedge sys_clk);
    arrayEvents = '0;
  endtask : pulse

  task automatic t_reset();
    logic [7:0] v;
    logic [15:0] tbl [11] = '{16'h08FF, 16'h0A55, 16'h0BFF, 16'h0C00, 16'h0DF0, 16'h0EFF,
      16'h0FFF, 16'h10FF, 16'h1100, 16'h12FF, 16'hFFFF};
    chk(integrityCtrl, `VCR_CTRL_RESET);
    chk(trainingPatternValue, `VCR_TRAIN_RESET);
    chk({5'h00, errorPinN, writeEnableLatch, flagStatusWriteError}, 8'h04);
    foreach (tbl[i]) begin
      rd(tbl[i][15:8], v);
      chk(v, tbl[i][7:0]);
    end
  endtask : t_reset

  task automatic t_write();
    logic [7:0] v, d;
    wr(`VCR_TRAIN_PATTERN, 8'h3C, 1'b0);
    chk(trainingPatternValue, 8'h55);
    wr(`VCR_TRAIN_PATTERN, 8'h3C, 1'b1);
    chk({trainingPatternValue[6:0], writeEnableLatch}, 8'h78);
    rd(`VCR_TRAIN_PATTERN, v);
    chk(v, 8'h3C);
    for (int k = 0; k < 4; k++) begin
      d = {2'b00, 2'(k), 4'b0100};
      wr(`VCR_INTEGRITY_CTRL, d, 1'b1);
      chk(integrityCtrl, d);
      chk(laneInvertMask, `VCR_LANE3_MASK);
      rd(`VCR_INTEGRITY_CTRL, v);
      chk(v, d);
    end
  endtask : t_write

  task automatic t_reserved();
    logic [7:0] v;
    wr(`VCR_INTEGRITY_STAT, 8'hFF, 1'b1);
    chk({6'h00, flagStatusWriteError, writeEnableLatch}, 8'h02);
    rd(`VCR_INTEGRITY_STAT, v);
    chk(v, 8'h00);
    @(negedge sys_clk) flagStatusClear = 1'b1;
    @(negedge sys_clk) flagStatusClear = 1'b0;
    chk({7'h00, flagStatusWriteError}, 8'h00);
    wr(8'h42, 8'h00, 1'b1);
    chk({6'h00, flagStatusWriteError, writeEnableLatch}, 8'h02);
  endtask : t_reserved

  // Control is 34h here: ECC on, pin on, double select
  task automatic t_events();
    logic [7:0] v;
    pulse(5, 28'h0AB_CDEF);
    rd(`VCR_INTEGRITY_STAT, v);
    chk({v[6:0], errorPinN}, 8'h11);
    repeat (15) pulse(5, 28'h0AB_CDEF);
    rd(`VCR_INTEGRITY_STAT, v);
    chk(v, 8'h78);
    pulse(4, 28'h123_4567);
    pulse(4, 28'h765_4321);
    rd(`VCR_INTEGRITY_STAT, v);
    chk({v[6:0], errorPinN}, 8'hF8);
    for (int i = 0; i < 4; i++) begin
      rd(`VCR_FIRST_ADDR_LOW + 8'(i), v);
      chk(v, 8'(32'h1234_5670 >> (8 * i)));
    end
    wr(`VCR_INTEGRITY_CTRL, 8'h30, 1'b1);
    pulse(5, 28'h000_0001);
    chk({7'h00, errorPinN}, 8'h00);
    pulse(3, 28'h000_0002);
    rd(`VCR_INTEGRITY_STAT, v);
    chk(v, 8'hFC);
    pulse(2, 28'h000_0003);
    rd(`VCR_INTEGRITY_STAT, v);
    chk(v, 8'hFE);
    pulse(0, 28'h000_0004);
    rd(`VCR_INTEGRITY_STAT, v);
    chk(v, 8'hFF);
  endtask : t_events

  task automatic t_bank();
    logic [7:0] v;
    for (int b = 0; b < 5; b++) begin
      @(negedge sys_clk);
      progEraseActive = (b < 4);
      progEraseBank = 2'(b);
      rd(`VCR_BANK_ACTIVITY, v);
      chk(v, (b < 4) ? {5'h00, 1'b1, 2'(b)} : 8'h00);
    end
  endtask : t_bank

  // Second reset in mid-run
  task automatic t_rerst();
    logic [7:0] v;
    @(negedge sys_clk) rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(`VCR_INTEGRITY_STAT, v);
    chk(v, `VCR_STAT_RESET);
    chk(integrityCtrl, 8'hFF);
    chk(laneInvertMask, 8'h00);
    // Unknown opcode: frame ignored, latch kept
    host_u.frame({`VCR_OP_WRITE_ENABLE, 40'h00_0000_0000}, 8, v);
    host_u.frame({8'h3B, 24'h00_0000, `VCR_TRAIN_PATTERN, 8'hAA}, 48, v);
    chk({trainingPatternValue[6:0], writeEnableLatch}, 8'hAB);
    // Correction select: pin idle until a double or correction event, correction address kept
    wr(`VCR_INTEGRITY_CTRL, 8'h30, 1'b1);
    chk({7'h00, errorPinN}, 8'h01);
    pulse(4, 28'h0DE_F012);
    pulse(5, 28'h0BA_9876);
    rd(`VCR_FIRST_ADDR_TOP, v);
    chk(v, 8'h0B);
    chk({7'h00, errorPinN}, 8'h00);
  endtask : t_rerst

  // Cut a hang short
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    arrayEvents = '0;
    progEraseActive = 1'b0;
    progEraseBank = 2'b00;
    flagStatusClear = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_write();
    t_reserved();
    t_events();
    t_bank();
    t_rerst();
    chk(8'(host_u.oeMiss), 8'h00);
    end_sim();
  end
endmodule : tb_flash_volatile_config_regs
